// ==== bench/ilu_chk.sv ====
module ilu_chk
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Register port.
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  // Acceptance.
  input wire logic instr_boundary,
  input wire logic interrupt_request,
  input wire logic accept_busy,
  input wire logic accept_done,
  input wire logic [3:0] accept_source,
  input wire logic saved_master_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_take;
    instr_boundary && interrupt_request && !accept_busy && !accept_done;
  endsequence
  a_take_start: assert property (s_take |=> accept_busy) else $error("acceptance not started");
  a_accept_len: assert property ($rose(accept_busy) |-> ##7 accept_done) else $error("bad length");
  a_done_pulse: assert property (accept_done |=> !accept_done) else $error("done too long");
  a_source_hold: assert property (!$rose(accept_busy) |-> $stable(accept_source)) else $error("source moved");
  a_saved_hold: assert property (!$rose(accept_busy) |-> $stable(saved_master_enable)) else $error("save moved");
  a_hit_map: assert property (sfr_hit == ($past(sfr_addr) inside {[8'h3a:8'h3d]})) else $error("bad hit");
  a_miss_zero: assert property (!sfr_hit |-> sfr_rdata == 8'h00) else $error("unmapped data");
  a_reset_quiet: assert property ($fell(reset) |-> !accept_busy && !interrupt_request) else $error("busy");
endmodule : ilu_chk

bind ilu_core ilu_chk ilu_chk_inst(.clk, .reset, .sfr_addr, .sfr_rdata, .sfr_hit, .instr_boundary,
  .interrupt_request, .accept_busy, .accept_done, .accept_source, .saved_master_enable);

// ==== bench/ilu_core_model.sv ====
module ilu_core_model
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // From the block.
  input wire logic accept_done,
  input wire logic saved_master_enable,
  // To the block.
  output logic instr_boundary = 0,
  output logic return_op = 0,
  output logic stacked_master_enable = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 0;
  logic [3:0] ret = 0;
  // An instruction ends every fourth cycle; each service returns eight cycles after entry.
  always @(posedge clk)
  begin
    cnt <= #1 reset ? 4'h0 : cnt + 4'h1;
    instr_boundary <= #1 !reset && cnt[1:0] == 2'h3;
    if (accept_done) stacked_master_enable <= #1 saved_master_enable;
    ret <= #1 reset ? 4'h0 : accept_done ? 4'h8 : ret - 4'(ret != 4'h0);
    return_op <= #1 ret == 4'h1;
  end
endmodule : ilu_core_model

// ==== bench/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, sfr_write = 0, unmask_all_op = 0, mask_all_op = 0;
  logic [15:0] request = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
  logic sfr_hit, instr_boundary, return_op, stacked_master_enable, saved_master_enable;
  logic interrupt_request, accept_busy, accept_done;
  logic [3:0] accept_source;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  ilu_core ilu_core_inst(.clk, .reset, .request, .sfr_addr, .sfr_write, .sfr_wdata, .sfr_rdata, .sfr_hit,
    .instr_boundary, .unmask_all_op, .mask_all_op, .return_op, .stacked_master_enable, .interrupt_request,
    .accept_busy, .accept_done, .accept_source, .saved_master_enable);
  ilu_core_model ilu_core_model_inst(.clk, .reset, .accept_done, .saved_master_enable, .instr_boundary,
    .return_op, .stacked_master_enable);
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_write = 1;
    @(posedge clk);
    #1 sfr_write = 0;
    request = 0;
    @(posedge clk);
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    @(posedge clk);
    #1 chk(sfr_rdata, exp);
    chk(sfr_hit, a inside {[8'h3a:8'h3d]});
  endtask : rd
  task req(input logic [15:0] r);
    request = r;
    @(posedge clk);
    #1 request = 0;
  endtask : req
  task pulse_master(input logic on);
    unmask_all_op = on;
    mask_all_op = !on;
    @(posedge clk);
    #1 unmask_all_op = 0;
    mask_all_op = 0;
  endtask : pulse_master
  task wait_done(input logic [3:0] src);
    int i;
    i = 0;
    @(posedge clk);
    #1;
    while (accept_done !== 1'b1 && i < 40)
    begin
      @(posedge clk);
      #1 i++;
    end
    chk(accept_done, 8'h01);
    chk(accept_source, src);
    chk(accept_busy, 8'h00);
  endtask : wait_done
  task t_reset;
    rd(8'h3a, 8'h00);
    rd(8'h3b, 8'h00);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h3a, 8'hfe);
    rd(8'h3a, 8'hf0);
    wr(8'h3b, 8'ha5);
    rd(8'h3b, 8'ha5);
    wr(8'h3b, 8'h00);
    wr(8'h3a, 8'h00);
    $display("t_reset end");
  endtask : t_reset
  task t_latch;
    req(16'h1033);
    chk(interrupt_request, 8'h00);
    rd(8'h3c, 8'h30);
    rd(8'h3d, 8'h10);
    wr(8'h3c, 8'hef);
    rd(8'h3c, 8'h20);
    wr(8'h3c, 8'hff);
    rd(8'h3c, 8'h20);
    request = 16'h0020;
    wr(8'h3c, 8'hdf);
    rd(8'h3c, 8'h20);
    wr(8'h3c, 8'hdf);
    wr(8'h3d, 8'h00);
    rd(8'h3c, 8'h00);
    rd(8'h3d, 8'h00);
    $display("t_latch end");
  endtask : t_latch
  task t_accept;
    wr(8'h3a, 8'h40);
    req(16'h0040);
    chk(interrupt_request, 8'h00);
    pulse_master(1);
    chk(interrupt_request, 8'h01);
    wait_done(4'h6);
    chk(saved_master_enable, 8'h01);
    rd(8'h3c, 8'h00);
    rd(8'h3a, 8'h40);
    repeat (8) @(posedge clk);
    #1 rd(8'h3a, 8'h41);
    pulse_master(0);
    rd(8'h3a, 8'h40);
    req(16'h0008);
    wait_done(4'h3);
    chk(saved_master_enable, 8'h00);
    repeat (12) @(posedge clk);
    #1 rd(8'h3c, 8'h00);
    $display("t_accept end");
  endtask : t_accept
  task t_prio;
    wr(8'h3a, 8'hf0);
    req(16'h00a0);
    pulse_master(1);
    wait_done(4'h5);
    wait_done(4'h7);
    pulse_master(0);
    wr(8'h3a, 8'h00);
    $display("t_prio end");
  endtask : t_prio
  task stop_test;
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      stop_test;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    #1 reset = 0;
    t_reset;
    t_latch;
    t_accept;
    t_prio;
    stop_test;
  end
endmodule : testbench

// ==== hdl/ilu_core.sv ====
// Behaviour
// - One pending latch for sources 2 to 15; software and undefined-op sources have none.
// - A hardware request sets its latch; enabled latches request acceptance from the core.
// - The serviced source's latch is cleared as part of acceptance.
// - Reset clears all pending latches.
// - Pending latches read and write as low byte 3C and high byte 3D.
// - Writing 0 clears that latch alone; writing 1 leaves it unchanged.
// - Software writes never set a pending latch.
// - Reads return the current pending latch state.
// - Non-maskable sources are accepted regardless of the enable register.
// - Enable register sits at 3A and 3B, readable and writable except bits 3 to 1 of 3A, which read as zero.
// - Master enable at 0 blocks every maskable interrupt.
// - With master enable 1, a maskable source also needs its own enable.
// - Acceptance exposes the old master enable for stacking, then clears it.
// - Either return instruction reloads master enable from the stacked value.
// - Master enable is bit 0 of the low enable byte; set and clear ops.
// - Reset clears master enable.
// - Per-source enables occupy bits 15 to 4; 1 enables, 0 disables.
// - Reset clears all per-source enables.
// - Simultaneous requests are accepted in a fixed hardware priority order.
// - Acceptance completes in 8 machine cycles after the current instruction.
module ilu_core
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Hardware requests, one-cycle pulses, bit index equals source number.
  input wire logic [15:0] request,
  // Special function area byte port.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_write,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Core instruction events, one-cycle pulses, then the stacked master enable level.
  input wire logic instr_boundary,
  input wire logic unmask_all_op,
  input wire logic mask_all_op,
  input wire logic return_op,
  input wire logic stacked_master_enable,
  // Acceptance handshake toward the core.
  output logic interrupt_request,
  output logic accept_busy,
  output logic accept_done,
  output logic [3:0] accept_source,
  output logic saved_master_enable
);
  import ilu_pkg::*;

  logic [15:0] pending_latch;
  logic master_enable;
  logic [15:4] source_enable;
  ilu_state_t state;
  logic [3:0] cycle_count;
  logic clear_pending;
  logic [15:0] candidates;
  logic found;
  logic [3:0] winner;
  logic [15:0] next_pending;
  logic [15:0] write_keep;
  logic write_enable_low;
  logic write_enable_high;
  logic write_pending_low;
  logic write_pending_high;
  logic last_cycle;
  logic [7:0] next_rdata;
  logic next_hit;
  logic next_master_enable;
  logic [15:4] next_source_enable;

  function automatic logic [15:0] ilu_onehot(input logic [3:0] index);
    ilu_onehot = 16'h0001 << index;
  endfunction : ilu_onehot

  // True when this cycle writes the byte at the given address.
  function automatic logic ilu_writes(input logic write, input logic [7:0] addr, input logic [7:0] target);
    ilu_writes = write && (addr == target);
  endfunction : ilu_writes

  // Byte write strobes, one for each mapped address.
  assign write_enable_low = ilu_writes(sfr_write, sfr_addr, ilu_addr_enable_low);
  assign write_enable_high = ilu_writes(sfr_write, sfr_addr, ilu_addr_enable_high);
  assign write_pending_low = ilu_writes(sfr_write, sfr_addr, ilu_addr_pending_low);
  assign write_pending_high = ilu_writes(sfr_write, sfr_addr, ilu_addr_pending_high);

  // Maskable candidates need master and own enable; non-maskable ones do not.
  // The registered master enable is used, so an unmask takes effect on the following cycle.
  always_comb
  begin
    candidates = 16'h0000;
    candidates[ilu_trap_bit] = pending_latch[ilu_trap_bit];
    candidates[ilu_watchdog_bit] = pending_latch[ilu_watchdog_bit];
    if (master_enable)
    begin
      candidates[15:4] = pending_latch[15:4] & source_enable;
    end
  end

  ilu_priority u_priority
  (
    .candidates(candidates),
    .found(found),
    .source(winner)
  );

  assign interrupt_request = found;
  assign accept_busy = (state == ilu_accepting);
  assign clear_pending = (state == ilu_idle) && instr_boundary && found;
  // Last busy cycle of the acceptance sequence.
  assign last_cycle = (state == ilu_accepting) && (cycle_count == 4'(ilu_accept_cycles - 1));

  // Write mask: a written 0 clears, a written 1 keeps.
  always_comb
  begin
    write_keep = 16'hffff;
    if (write_pending_low)
    begin
      write_keep[7:0] = sfr_wdata;
    end
    if (write_pending_high)
    begin
      write_keep[15:8] = sfr_wdata;
    end
    if (clear_pending)
    begin
      write_keep = write_keep & ~ilu_onehot(winner);
    end
    // Requests override any clear in the same cycle; writes only ever clear.
    next_pending = ((pending_latch & write_keep) | request) & ilu_latch_mask;
  end

  // Pending latches, cleared only by reset, software or acceptance.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pending_latch <= ilu_pending_reset;
    end
    else
    begin
      pending_latch <= next_pending;
    end
  end

  // Acceptance sequence, started at an instruction boundary.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ilu_idle;
      cycle_count <= 4'h0;
    end
    else
    begin
      case (state)
        ilu_idle:
        begin
          if (clear_pending)
          begin
            state <= ilu_accepting;
            cycle_count <= 4'h1;
          end
        end
        ilu_accepting:
        begin
          if (last_cycle)
          begin
            state <= ilu_done;
          end
          cycle_count <= cycle_count + 4'h1;
        end
        ilu_done:
        begin
          state <= ilu_idle;
        end
        default:
        begin
          state <= ilu_idle;
        end
      endcase
    end
  end

  // Source number and old master enable stand until the next acceptance.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      accept_source <= 4'h0;
      saved_master_enable <= 1'b0;
    end
    else if (clear_pending)
    begin
      accept_source <= winner;
      saved_master_enable <= master_enable;
    end
  end

  // One-cycle pulse as the last busy cycle ends.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      accept_done <= 1'b0;
    end
    else
    begin
      accept_done <= last_cycle;
    end
  end

  // Acceptance outranks return, return outranks the single-flag ops, and those outrank a register write.
  always_comb
  begin
    next_master_enable = master_enable;
    if (clear_pending)
    begin
      next_master_enable = 1'b0;
    end
    else if (return_op)
    begin
      next_master_enable = stacked_master_enable;
    end
    else if (unmask_all_op)
    begin
      next_master_enable = 1'b1;
    end
    else if (mask_all_op)
    begin
      next_master_enable = 1'b0;
    end
    else if (write_enable_low)
    begin
      next_master_enable = sfr_wdata[ilu_master_bit];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      master_enable <= 1'b0;
    end
    else
    begin
      master_enable <= next_master_enable;
    end
  end

  // Per-source enables; the low byte shares its write with the master enable.
  always_comb
  begin
    next_source_enable = source_enable;
    if (write_enable_low)
    begin
      next_source_enable[7:4] = sfr_wdata[7:4];
    end
    if (write_enable_high)
    begin
      next_source_enable[15:8] = sfr_wdata;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      source_enable <= ilu_enable_reset[15:4];
    end
    else
    begin
      source_enable <= next_source_enable;
    end
  end

  // Read data for the addressed byte; unused enable bits and unmapped bytes read as zero.
  always_comb
  begin
    next_rdata = 8'h00;
    next_hit = 1'b1;
    case (sfr_addr)
      ilu_addr_enable_low: next_rdata = {source_enable[7:4], 3'b000, master_enable};
      ilu_addr_enable_high: next_rdata = source_enable[15:8];
      ilu_addr_pending_low: next_rdata = pending_latch[7:0];
      ilu_addr_pending_high: next_rdata = pending_latch[15:8];
      default:
      begin
        next_hit = 1'b0;
      end
    endcase
  end

  // Registered so that read data is a flip-flop output, one cycle after the address.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end
    else
    begin
      sfr_rdata <= next_rdata;
      sfr_hit <= next_hit;
    end
  end
endmodule : ilu_core

// ==== hdl/ilu_priority.sv ====
module ilu_priority
(
  // Candidates, bit index equals source number.
  input wire logic [15:0] candidates,
  // Winner.
  output logic found,
  output logic [3:0] source
);
  import ilu_pkg::*;

  // Lowest index wins, so trap (bit 2) outranks watchdog (bit 3) and every maskable source.
  always_comb
  begin
    found = 1'b0;
    source = 4'h0;
    for (int i = 15; i >= ilu_first_latch; i--)
    begin
      if (candidates[i])
      begin
        found = 1'b1;
        source = 4'(i);
      end
    end
  end
endmodule : ilu_priority

// ==== shared/ilu_pkg.sv ====
package ilu_pkg;
  localparam logic [7:0] ilu_addr_enable_low = 8'h3a;
  localparam logic [7:0] ilu_addr_enable_high = 8'h3b;
  localparam logic [7:0] ilu_addr_pending_low = 8'h3c;
  localparam logic [7:0] ilu_addr_pending_high = 8'h3d;
  localparam int ilu_first_latch = 2;
  localparam int ilu_trap_bit = 2;
  localparam int ilu_watchdog_bit = 3;
  localparam int ilu_first_maskable = 4;
  localparam int ilu_master_bit = 0;
  localparam logic [15:0] ilu_pending_reset = 16'h0000;
  localparam logic [15:0] ilu_enable_reset = 16'h0000;
  localparam logic [15:0] ilu_latch_mask = 16'hfffc;
  localparam logic [15:0] ilu_enable_mask = 16'hfff1;
  localparam int ilu_accept_cycles = 8;
  typedef enum logic [2:0]
  {
    ilu_idle = 3'b001,
    ilu_accepting = 3'b010,
    ilu_done = 3'b100
  } ilu_state_t;
endpackage : ilu_pkg
